// *** core/acsp_buf2.sv ***
// Purpose: Two entry buffer with valid and ready on both sides
// Assumes: Single clock
// Notes:   Full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module acsp_buf2
    import acsp_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    input  wire acsp_word_t in_data_i,
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output acsp_word_t      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    acsp_word_t      mem_q [DEPTH];   // Storage array
    logic [AW-1:0]   wr_q;            // Write pointer
    logic [AW-1:0]   rd_q;            // Read pointer
    logic [AW:0]     cnt_q;           // Fill level
    wire             push = in_valid_i && in_ready_o;
    wire             pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];

    // Storage write, no reset needed on data
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and level
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // acsp_buf2
`default_nettype wire

// *** core/acsp_core.sv ***
// Purpose: Sequence select, conversion sequencer and parallel port of a
//          four channel simultaneous sampling converter
// Assumes: All pins asynchronous, synchronised here; analog front end
//          supplies sample words through sample_data_i
// Notes:   Bracketed tags mark the logic of each rule but RQ19, which is left to the host
// Function
// RQ1 - Hardware mode: pin two includes channel 2
// RQ2 - Software mode ignores hardware select pins
// RQ3 - Pins three, four include channels 3, 4
// RQ4 - Select pin high includes its channel
// RQ5 - Select pin low excludes its channel
// RQ6 - Selector low: pins, internal clock only
// RQ7 - Selector high: mask, internal or external
// RQ8 - Standby low stops operation, saves power; here it only refuses a start while idle, a running sequence goes on
// RQ9 - 14-bit result word, bit 13 MSB
// RQ10 - Twos complement bipolar, binary unipolar
// RQ11 - Low four lines bidirectional for writes
// RQ12 - Host writes mask over low lines
// RQ13 - Mask bit 0 channel 1, bit 3 channel 4
// RQ14 - One low pulse per finished conversion
// RQ15 - Start rise holds, latches, starts sequence
// RQ16 - Write rise with select low, read high
// RQ17 - Busy high from start to last channel
// RQ18 - Outputs enabled while read, select low
// RQ19 - Host programs mask before first start
`include "acsp_params.svh"
`timescale 1ns/100ps
`default_nettype none
module acsp_core
    import acsp_pkg::*;
#(
    parameter int  CONV_TICKS = `ACSP_CONV_TICKS,   // Ticks per conversion
    parameter int  INT_DIV    = `ACSP_INT_DIV,      // Internal tick divider
    parameter bit  UNIPOLAR   = 1'b0                // Straight binary coding
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // Pins
    input  wire logic        convert_start_i,
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        hw_sw_select_i,
    input  wire logic        standby_n_i,
    input  wire logic        clk_in_hw_chan1_include_i,
    input  wire logic        clock_source_select_hw_chan2_include_i,
    input  wire logic        hw_chan3_include_i,
    input  wire logic        hw_chan4_include_i,
    input  wire logic [3:0]  result_bus_low_i,
    output logic [13:0]      result_bus_o,
    output logic [13:0]      result_bus_oe_n_o,
    output logic             busy_o,
    output logic             eoc_n_o,
    output logic             first_result_flag_o,
    output logic             track_hold_hold_o,
    output logic             standby_o,
    // Analog side: raw offset binary sample per channel
    input  wire logic [55:0] sample_data_i
);
    // Every check in here runs on the one clock, off in reset
    default clocking cb_chk @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    //------------------------------------------------------------
    // Pin synchronisation
    //------------------------------------------------------------
    logic [9:0] pins_s;     // Synchronised pins, active low ones inverted
    // Inverted so the flops' reset value reads as idle: no read in reset
    acsp_sync #(.W(10)) u_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .d_i       ({convert_start_i, ~cs_n_i, ~rd_n_i, ~wr_n_i, hw_sw_select_i,
                     ~standby_n_i, clk_in_hw_chan1_include_i,
                     clock_source_select_hw_chan2_include_i,
                     hw_chan3_include_i, hw_chan4_include_i}),
        .q_o       (pins_s)
    );
    // Low four lines carry their own sync stages
    logic [3:0] db_s;
    acsp_sync #(.W(4)) u_sync_db (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .d_i       (result_bus_low_i),
        .q_o       (db_s)
    );

    wire conv_s  = pins_s[9];   // Convert start
    wire cs_n_s  = !pins_s[8];  // Chip select
    wire rd_n_s  = !pins_s[7];  // Read strobe
    wire wr_n_s  = !pins_s[6];  // Write strobe
    wire sw_s    = pins_s[5];   // Hardware low, software high
    wire standby_n_s  = !pins_s[4];  // Standby, active low
    wire sl1_s   = pins_s[3];   // Select 1 or external clock
    wire sl2_s   = pins_s[2];   // Select 2 or clock source
    wire sl3_s   = pins_s[1];   // Select 3
    wire sl4_s   = pins_s[0];   // Select 4

    //------------------------------------------------------------
    // Edge detection
    //------------------------------------------------------------
    logic conv_d1_q;    // Previous convert start
    logic wr_d1_q;      // Previous write strobe
    logic ext_d1_q;     // Previous external clock
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conv_d1_q <= 1'b0;
            wr_d1_q   <= 1'b1;
            ext_d1_q  <= 1'b0;
        end else begin
            conv_d1_q <= conv_s;
            wr_d1_q   <= wr_n_s;
            ext_d1_q  <= sl1_s;
        end
    end
    wire conv_rise = conv_s && !conv_d1_q;
    wire wr_rise   = wr_n_s && !wr_d1_q;
    wire ext_rise  = sl1_s && !ext_d1_q;
    wire active    = standby_n_s;                               // [RQ8]

    //------------------------------------------------------------
    // Channel mask register
    //------------------------------------------------------------
    logic [3:0] conversion_channel_mask_q;  // Bit n selects channel n+1
    // Strobe taken on write rise with select low, read high
    wire mask_load = wr_rise && !cs_n_s && rd_n_s;          // [RQ16]
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conversion_channel_mask_q <= `ACSP_MASK_RESET;
        end else if (mask_load) begin
            conversion_channel_mask_q <= db_s;               // [RQ12] [RQ13] [RQ11]
        end
    end

    // Mask moves only on an accepted write strobe
    property p_mask_hold;
        !mask_load |=> $stable(conversion_channel_mask_q);
    endproperty
    a_mask_hold: assert property (p_mask_hold) // [RQ16]
        else $error("mask changed without a write");

    //------------------------------------------------------------
    // Sequence selection
    //------------------------------------------------------------
    // Pin high includes, low excludes; pins unused for selection in software mode
    wire [3:0] hw_sel = {sl4_s, sl3_s, sl2_s, sl1_s};       // [RQ1] [RQ3] [RQ4] [RQ5]
    wire [3:0] sel_now = sw_s ? conversion_channel_mask_q   // [RQ2] [RQ7]
                              : hw_sel;                      // [RQ6]
    // External clock only in software mode with source select high
    wire use_ext   = sw_s && sl2_s;                          // [RQ6] [RQ7]

    //------------------------------------------------------------
    // Conversion tick: internal divider or external clock edge
    //------------------------------------------------------------
    logic [$clog2(INT_DIV+1)-1:0] div_q;   // Internal divider
    wire int_tick = (div_q == '0);
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= '0;
        end else begin
            div_q <= int_tick ? ($bits(div_q))'(INT_DIV - 1) : div_q - 1'b1;
        end
    end

    //------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------
    acsp_state_t state_q;          // Sequencer state
    logic [3:0]  seq_q;            // Latched channels still to convert
    logic [1:0]  chan_q;           // Channel in conversion
    logic [4:0]  tick_q;           // Ticks left in conversion
    logic [1:0]  eoc_cnt_q;        // End pulse width counter
    logic        use_ext_q;        // Clock source latched at start
    logic [55:0] hold_q;           // Held samples
    logic        first_done_q;     // Word on the bus is from channel 1
    // Tick source follows the clock choice latched at start
    wire tick = use_ext_q ? ext_rise : int_tick;

    // Lowest remaining channel goes first
    wire [1:0] next_chan = seq_q[0] ? 2'd0 : seq_q[1] ? 2'd1 :
                           seq_q[2] ? 2'd2 : 2'd3;
    wire       seq_empty = (seq_q == '0);

    // Output coding: flip MSB for twos complement
    wire [13:0] raw_word = hold_q[chan_q*14 +: 14];
    wire [13:0] coded    = UNIPOLAR ? raw_word                      // [RQ10]
                                    : {~raw_word[13], raw_word[12:0]};
    acsp_word_t push_word;
    assign push_word.chan = chan_q;
    assign push_word.data = coded;
    logic push_v;
    logic push_rdy;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q      <= ST_IDLE;
            seq_q        <= '0;
            chan_q       <= '0;
            tick_q       <= '0;
            eoc_cnt_q    <= '0;
            use_ext_q    <= 1'b0;
            hold_q       <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    // Start rise: hold inputs, latch selection
                    if (conv_rise && active && sel_now != '0) begin
                        hold_q    <= sample_data_i;            // [RQ15]
                        seq_q     <= sel_now;                  // [RQ15]
                        use_ext_q <= use_ext;
                        state_q   <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (seq_empty) begin
                        state_q <= ST_IDLE;
                    end else begin
                        chan_q  <= next_chan;
                        seq_q[next_chan] <= 1'b0;
                        tick_q  <= 5'(CONV_TICKS);
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // Stall on full buffer so no word is lost
                    if (tick && tick_q != '0) begin
                        tick_q <= tick_q - 5'd1;
                    end else if (tick_q == '0 && push_rdy) begin
                        eoc_cnt_q <= 2'(`ACSP_EOC_PULSE_CYC);
                        state_q   <= ST_EOC;
                    end
                end
                ST_EOC: begin
                    if (eoc_cnt_q == 2'd1) begin
                        state_q <= ST_NEXT;
                    end
                    eoc_cnt_q <= eoc_cnt_q - 2'd1;
                end
            endcase
        end
    end
    assign push_v = (state_q == ST_CONV) && (tick_q == '0);

    // Busy from start until last selected channel done
    assign busy_o = (state_q != ST_IDLE);                       // [RQ17]
    assign track_hold_hold_o = busy_o;                          // [RQ15]
    assign eoc_n_o = (state_q != ST_EOC);                       // [RQ14]
    assign standby_o = !active;                                 // [RQ8]

    //------------------------------------------------------------
    // Sequencer checks
    //------------------------------------------------------------
    // Start taken by the idle sequencer, and its two flavours
    sequence s_start_taken;
        (state_q == ST_IDLE) && conv_rise && active && (sel_now != '0);
    endsequence
    sequence s_start_hw;
        s_start_taken ##0 !sw_s;
    endsequence
    sequence s_start_sw;
        s_start_taken ##0 sw_s;
    endsequence

    // Busy and hold rise right after a taken start
    property p_start_busy;
        s_start_taken |=> busy_o && track_hold_hold_o;
    endproperty
    a_start_busy: assert property (p_start_busy) // [RQ15] [RQ17]
        else $error("start did not raise busy");

    // Pin mode latches the four select pins
    property p_seq_hw;
        s_start_hw |=> seq_q == $past(hw_sel);
    endproperty
    a_seq_hw: assert property (p_seq_hw) // [RQ1] [RQ3] [RQ4] [RQ5] [RQ6]
        else $error("pin selection not latched");

    // Mask mode latches the register; pins have no say
    property p_seq_sw;
        s_start_sw |=> seq_q == $past(conversion_channel_mask_q);
    endproperty
    a_seq_sw: assert property (p_seq_sw) // [RQ2] [RQ7] [RQ13]
        else $error("mask selection not latched");

    // Each end pulse is low for two cycles, then high
    property p_eoc_width;
        $fell(eoc_n_o) |=> !eoc_n_o ##1 eoc_n_o;
    endproperty
    a_eoc_width: assert property (p_eoc_width) // [RQ14]
        else $error("end pulse width wrong");

    // Standby keeps the sequencer idle
    property p_standby_n_idle;
        !active && (state_q == ST_IDLE) |=> state_q == ST_IDLE;
    endproperty
    a_standby_n_idle: assert property (p_standby_n_idle) // [RQ8]
        else $error("start taken in standby");

    // Busy stands while a channel is still in work
    property p_busy_hold;
        (state_q == ST_CONV) || (state_q == ST_EOC) |=> busy_o;
    endproperty
    a_busy_hold: assert property (p_busy_hold) // [RQ17]
        else $error("busy fell mid sequence");

    //------------------------------------------------------------
    // Result buffer
    //------------------------------------------------------------
    acsp_word_t out_word;
    logic       out_v;
    wire        rd_active = !cs_n_s && !rd_n_s;
    logic       rd_d1_q;                   // Previous read enable
    wire        rd_end = rd_d1_q && !rd_active;
    acsp_buf2 #(.DEPTH(2)) u_buf (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (push_v),
        .in_ready_o  (push_rdy),
        .in_data_i   (push_word),
        .out_valid_o (out_v),
        .out_ready_i (rd_end),
        .out_data_o  (out_word)
    );

    //------------------------------------------------------------
    // Read port: registered data, drivers on during read
    //------------------------------------------------------------
    logic [13:0] rd_data_q;   // Word on the bus
    logic        first_q;     // Word belongs to channel 1
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_d1_q   <= 1'b0;
            rd_data_q <= '0;
            first_q   <= 1'b0;
        end else begin
            rd_d1_q   <= rd_active;
            rd_data_q <= out_v ? out_word.data : '0;           // [RQ9]
            first_q   <= out_v && (out_word.chan == 2'd0);
        end
    end
    assign first_done_q = first_q;
    assign result_bus_o = rd_data_q;                            // [RQ9]
    // Enable low while driving; write strobe high assumed in reads
    assign result_bus_oe_n_o = {14{!(rd_active && wr_n_s)}};   // [RQ18] [RQ11]
    assign first_result_flag_o = first_done_q;

    // Drivers stay off unless a read is under way
    property p_oe_off;
        !rd_active |-> result_bus_oe_n_o == 14'h3fff;
    endproperty
    a_oe_off: assert property (p_oe_off) // [RQ18] [RQ11]
        else $error("drivers on outside a read");
endmodule // acsp_core
`default_nettype wire

// *** core/acsp_params.svh ***
// Purpose: Constants for the converter sequence select and parallel port
// Assumes: 250 MHz reference clock
// Notes:   Definitions only
`ifndef ACSP_PARAMS_SVH
`define ACSP_PARAMS_SVH

`define ACSP_NUM_CHAN        4
`define ACSP_RESULT_W        14
`define ACSP_MASK_W          4
`define ACSP_MASK_RESET      4'h0
`define ACSP_CONV_TICKS      16
`define ACSP_CLK_NS          4
`define ACSP_INT_TICK_NS     100
`define ACSP_INT_DIV         (`ACSP_INT_TICK_NS / `ACSP_CLK_NS)
`define ACSP_EOC_PULSE_CYC   2

`endif

// *** core/acsp_pkg.sv ***
// Purpose: Types for the converter sequence select and parallel port
// Assumes: Used with acsp_params.svh
// Notes:   Types only
package acsp_pkg;
    typedef struct packed {
        logic [1:0]  chan;    // Channel index, 0 for channel 1
        logic [13:0] data;    // Coded conversion word
    } acsp_word_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CONV  = 4'b0010,
        ST_EOC   = 4'b0100,
        ST_NEXT  = 4'b1000
    } acsp_state_t;
endpackage : acsp_pkg

// *** core/acsp_sync.sv ***
// Purpose: Two flop synchroniser for a bus of pin inputs
// Assumes: Inputs asynchronous to ref_clk_i
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module acsp_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q; // First stage, read only by second

    // Two stage capture
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // acsp_sync
`default_nettype wire

// *** verification/acsp_core_test.sv ***
// Purpose: Self-checking bench for sequence select and parallel port
// Assumes: Internal tick divider 1 to keep the run short
// Notes:   Bipolar coding: expected word is the raw sample, MSB inverted
`timescale 1ns/100ps
`default_nettype none
module acsp_core_test;
    logic        clk = 1'b0, nrst = 1'b0, conv_start = 1'b0;
    logic        hw_sw = 1'b0, standby_n_n = 1'b1;
    logic [3:0]  sel = 4'h0;                    // Select pins, bit 0 channel 1
    logic [13:0] samp [4] = '{14'h0123, 14'h2345, 14'h3abc, 14'h1f00};
    logic        cs_n, rd_n, wr_n, busy, eoc_n, frst, hold, standby_n_o;
    logic [3:0]  low;
    logic [13:0] dout, oe_n;
    int          error_cnt = 0, n_checks = 0, eoc_cnt = 0, low_run = 0;

    always #2 clk = ~clk;

    acsp_core #(.CONV_TICKS(16), .INT_DIV(1), .UNIPOLAR(1'b0)) acsp_core_i (
        .ref_clk_i(clk), .nrst_i(nrst), .convert_start_i(conv_start),
        .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .hw_sw_select_i(hw_sw),
        .standby_n_i(standby_n_n), .clk_in_hw_chan1_include_i(sel[0]),
        .clock_source_select_hw_chan2_include_i(sel[1]),
        .hw_chan3_include_i(sel[2]), .hw_chan4_include_i(sel[3]),
        .result_bus_low_i(low), .result_bus_o(dout), .result_bus_oe_n_o(oe_n),
        .busy_o(busy), .eoc_n_o(eoc_n), .first_result_flag_o(frst),
        .track_hold_hold_o(hold), .standby_o(standby_n_o),
        .sample_data_i({samp[3], samp[2], samp[1], samp[0]}));

    acsp_host_model acsp_host_model_i (
        .ref_clk_i(clk), .dev_data_i(dout), .dev_oe_n_i(oe_n), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .low_lines_o(low));

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor: pulse count and width, hold follows busy
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (nrst) begin
            if (hold !== busy) check_bit(hold, busy);
            if (eoc_n === 1'b0) begin
                if (low_run == 0) eoc_cnt++;
                low_run++;
            end else if (low_run != 0) begin
                check_cnt(low_run, 2);
                low_run = 0;
            end
        end
    end

    // ------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------
    task automatic start_conv();
        eoc_cnt = 0;
        @(posedge clk);
        conv_start <= 1'b1;
        repeat (5) @(posedge clk);
        conv_start <= 1'b0;
    endtask

    // Bounded wait for busy to reach a level
    task automatic wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 2000 && busy !== lvl; n++) @(negedge clk);
        if (busy !== lvl) begin
            error_cnt++;
            $display("unexpected at %0t: busy wait ran out", $time);
            tally_and_finish();
        end
    endtask

    // Read one word and compare with the coded sample of channel ch
    task automatic read_chk(input int ch);
        logic [13:0] d, oe;
        check_bit(frst, ch == 0);
        acsp_host_model_i.read_word(d, oe);
        check_word(d, samp[ch] ^ 14'h2000);
        check_word(oe, 14'h0000);
        repeat (4) @(negedge clk);
        check_word(oe_n, 14'h3fff);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // All pins high: buffer fills, sequence stalls until the host reads
    task automatic sc_hw_fill();
        @(posedge clk);
        hw_sw <= 1'b0;
        sel   <= 4'hf;
        start_conv();
        wait_busy(1'b1);
        repeat (200) @(negedge clk);
        check_bit(busy, 1'b1);
        read_chk(0);
        read_chk(1);
        wait_busy(1'b0);
        check_cnt(eoc_cnt, 4);
        read_chk(2);
        read_chk(3);
    endtask

    // Pins two and four only
    task automatic sc_hw_pick();
        @(posedge clk);
        sel <= 4'ha;
        start_conv();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_cnt(eoc_cnt, 2);
        read_chk(1);
        read_chk(3);
    endtask

    // Mask mode; pins select more channels than the mask, pin two low for internal clock
    task automatic sc_sw_mask();
        @(posedge clk);
        hw_sw <= 1'b1;
        sel   <= 4'hd;
        acsp_host_model_i.write_mask(4'h1, 1'b1);
        start_conv();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_cnt(eoc_cnt, 1);
        read_chk(0);
        acsp_host_model_i.write_mask(4'h8, 1'b1);
        acsp_host_model_i.write_mask(4'h2, 1'b0);
        start_conv();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_cnt(eoc_cnt, 1);
        read_chk(3);
    endtask

    // External clock: a conversion moves only on clock-in rises
    task automatic sc_ext_clk();
        @(posedge clk);
        sel <= 4'h2;
        start_conv();
        wait_busy(1'b1);
        repeat (60) @(posedge clk);
        check_cnt(eoc_cnt, 0);
        repeat (16) begin
            sel[0] <= 1'b1;
            repeat (3) @(posedge clk);
            sel[0] <= 1'b0;
            repeat (3) @(posedge clk);
        end
        wait_busy(1'b0);
        check_cnt(eoc_cnt, 1);
        read_chk(3);
    endtask

    // Standby refuses a start
    task automatic sc_standby();
        @(posedge clk);
        standby_n_n <= 1'b0;
        repeat (5) @(negedge clk);
        check_bit(standby_n_o, 1'b1);
        start_conv();
        repeat (40) @(negedge clk);
        check_bit(busy, 1'b0);
        @(posedge clk);
        standby_n_n <= 1'b1;
        repeat (5) @(negedge clk);
        check_bit(standby_n_o, 1'b0);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(negedge clk);
        check_bit(busy, 1'b0);
        check_word(oe_n, 14'h3fff);
        sc_hw_fill();
        sc_hw_pick();
        sc_sw_mask();
        sc_ext_clk();
        sc_standby();
        tally_and_finish();
    end
endmodule // acsp_core_test
`default_nettype wire

// *** verification/acsp_host_model.sv ***
// Purpose: Host side of the parallel port: chip select, read and write strobes
// Assumes: Strobes synchronised inside the device, so each is held at least 6 clocks
// Notes:   Low data lines resolved here from device enables and host drive
`timescale 1ns/100ps
`default_nettype none
module acsp_host_model (
    input  wire logic        ref_clk_i,
    input  wire logic [13:0] dev_data_i,     // Device data drivers
    input  wire logic [13:0] dev_oe_n_i,     // Device enables, low drives
    output logic             cs_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic [3:0]       low_lines_o     // Resolved low four lines
);
    logic       host_drv;   // Host drives the low lines
    logic [3:0] host_d;     // Host data
    logic [3:0] last_d;     // Last host value, inverted once released

    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // Released lines float: show the inverse so a stale latch is caught
    assign low_lines_o = (~dev_oe_n_i[3:0] & dev_data_i[3:0]) |
                         (dev_oe_n_i[3:0] & (host_drv ? host_d : ~last_d));

    initial begin
        cs_n_o   = 1'b1;
        rd_n_o   = 1'b1;
        wr_n_o   = 1'b1;
        host_drv = 1'b0;
        host_d   = 4'h0;
        last_d   = 4'h0;
    end

    // Mask write; sel low keeps chip select high so the write is foreign
    task automatic write_mask(input logic [3:0] m, input logic sel);
        @(posedge ref_clk_i);
        cs_n_o   <= ~sel;
        rd_n_o   <= 1'b1;    // Read held high through a write
        wr_n_o   <= 1'b0;
        host_d   <= m;       // Mask on the low lines
        last_d   <= m;
        host_drv <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        wr_n_o   <= 1'b1;    // Rising write strobe loads the mask
        repeat (4) @(posedge ref_clk_i);
        cs_n_o   <= 1'b1;
        host_drv <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // One word read; write strobe stays high throughout
    task automatic read_word(output logic [13:0] d, output logic [13:0] oe_n);
        @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        rd_n_o <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        d    = {dev_data_i[13:4], low_lines_o};
        oe_n = dev_oe_n_i;
        @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        @(posedge ref_clk_i);
    endtask
endmodule // acsp_host_model
`default_nettype wire
